// File: bench/ee_asserts.sv
/* checker for the link and the target's commit path.
   assumes it sits beside the interface joining both ends. */
`timescale 1ns/1ps
module ee_asserts #(
    parameter int WR_CYCLES = 2000
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaDevOe,
    input wire logic writeBusy,
    input wire logic standby,
    input wire logic memWe
);
    // ************************************************************
    // link and commit checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    int busyCnt_q;
    always_ff @(posedge core_clk) begin
        busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
    end

    dev_launch_a: assert property (
        $changed(sdaDevOe) |-> !scl && !$past(scl))
        else $error("target moved data while clock high");
    ack_hold_a: assert property (
        $rose(scl) && sdaDevOe |-> sdaDevOe [*8])
        else $error("acknowledge dropped during clock high");
    busy_quiet_a: assert property (
        writeBusy |-> !sdaDevOe)
        else $error("target answered during write cycle");
    commit_gate_a: assert property (
        memWe |-> writeBusy)
        else $error("store outside write cycle");
    commit_start_a: assert property (
        $rose(writeBusy) |-> ##[0:60] memWe)
        else $error("write cycle stored nothing");
    busy_span_a: assert property (
        $fell(writeBusy) |->
            busyCnt_q inside {[WR_CYCLES - 40:WR_CYCLES + 40]})
        else $error("write cycle length wrong");
    busy_awake_a: assert property (
        writeBusy |-> !standby)
        else $error("standby during write cycle");
    start_wake_a: assert property (
        standby && scl && $past(scl) && $fell(sda) |-> ##[1:40] !standby)
        else $error("start not seen from standby");
endmodule // ee_asserts

// File: bench/testbench.sv
/* bench: controller and target on one link, plus a second target
   on a link bit-banged by the bench for fault frames.
   assumes the shared package and design files compile first. */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin totalChecks++; if ((a) !== (e)) begin \
    failCount++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module testbench;
    // ************************************************************
    // clocks, ends and link
    // ************************************************************
    localparam int Q = 20;
    localparam int BUSY = 2000;
    logic        core_clk = 1'h0, linkClk = 1'h0, rst_b = 1'h0;
    logic        cmdValid, cmdReady, wrDataValid = 1'h0, wrDataReady;
    logic [1:0]  cmdOp;
    logic [15:0] cmdAddr;
    logic [5:0]  cmdLen;
    logic [7:0]  wrData = 8'h00, memData;
    logic        respValid, respNack, standby, writeBusy, memWe;
    logic        standby2, busy2, memWe2, ack;
    logic [12:0] memAddr;
    logic [15:0] a;
    logic [7:0]  dq[$], seen[int], expMem[int];
    int          failCount, totalChecks, weCnt, we2Cnt, idx;
    int          seed = 32'h3ACBCDFE;
    always #20 core_clk = ~core_clk;
    always #62.5 linkClk = ~linkClk;
    ee_if bus ();
    ee_if bus2 ();
    ee_host #(.PHASE_CYC(Q)) i_ee_host (.core_clk(core_clk),
        .rst_b(rst_b), .bus(bus), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .cmdLen(cmdLen), .wrDataValid(wrDataValid), .wrData(wrData),
        .wrDataReady(wrDataReady), .respValid(respValid),
        .respNack(respNack));
    ee_dev #(.WR_CYCLES(BUSY)) i_ee_dev (.core_clk(core_clk),
        .rst_b(rst_b), .linkClk(linkClk), .bus(bus), .standby(standby),
        .writeBusy(writeBusy), .memWe(memWe), .memAddr(memAddr),
        .memData(memData));
    ee_dev #(.WR_CYCLES(BUSY)) i_ee_dev_b (.core_clk(core_clk),
        .rst_b(rst_b), .linkClk(linkClk), .bus(bus2),
        .standby(standby2), .writeBusy(busy2), .memWe(memWe2),
        .memAddr(), .memData());
    ee_asserts #(.WR_CYCLES(BUSY)) i_ee_asserts (.core_clk(core_clk),
        .rst_b(rst_b), .scl(bus.scl), .sda(bus.sda),
        .sdaDevOe(bus.sdaDevOe), .writeBusy(writeBusy),
        .standby(standby), .memWe(memWe));
    // data advances once the controller has signalled it took a byte
    always @(negedge core_clk) begin
        if (wrDataReady === 1'h1) idx++;
        wrDataValid = idx < dq.size();
        wrData = wrDataValid ? dq[idx] : 8'h00;
        if (memWe === 1'h1) begin
            seen[memAddr] = memData;
            weCnt++;
        end
        if (memWe2 === 1'h1) we2Cnt++;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmd(input logic [1:0] op, input logic [15:0] ad,
                       input int len, input logic nack);
        int n;
        cmdOp = op; cmdAddr = ad; cmdLen = len[5:0]; cmdValid = 1'h1;
        for (n = 0; n < 99 && cmdReady !== 1'h1; n++) @(negedge core_clk);
        @(negedge core_clk);
        cmdValid = 1'h0;
        for (n = 0; n < 40000 && respValid !== 1'h1; n++)
            @(negedge core_clk);
        `CHK("resp", 1'h1, respValid)
        @(negedge core_clk);
        `CHK("nack", nack, respNack)
    endtask
    function automatic int slot(input logic [15:0] b, input int i);
        return int'({b[12:5], 5'(b[4:0] + i[4:0])});
    endfunction
    task automatic wr(input int n);
        logic [7:0] d;
        dq = {}; idx = 0; weCnt = 0; seen.delete(); expMem.delete();
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            dq.push_back(d);
            expMem[slot(a, i)] = d;
        end
        cmd(ee_pkg::OP_WRITE, a, n - 1, 1'h0);
        cmd(ee_pkg::OP_POLL, 16'h0000, 0, 1'h1);
        for (int i = 0; i < 3 * BUSY && writeBusy !== 1'h0; i++)
            @(negedge core_clk);
        repeat (Q) @(negedge core_clk);
        `CHK("standby", 1'h1, standby)
        cmd(ee_pkg::OP_POLL, 16'h0000, 0, 1'h0);
        `CHK("count", expMem.num(), weCnt)
        foreach (expMem[k])
            `CHK("byte", expMem[k], seen.exists(k) ? seen[k] : 8'hXX)
    endtask
    task automatic waitQ();
        repeat (Q) @(negedge core_clk);
    endtask
    task automatic bbBit(input logic b, output logic rd);
        bus2.sdaHostOe = ~b; waitQ(); bus2.scl = 1'h1; waitQ();
        rd = bus2.sda; waitQ(); bus2.scl = 1'h0; waitQ();
    endtask
    task automatic bbEdge(input logic st);
        bus2.sdaHostOe = ~st; waitQ(); bus2.scl = 1'h1; waitQ();
        bus2.sdaHostOe = st; waitQ();
        if (st) begin
            bus2.scl = 1'h0;
            waitQ();
        end
    endtask
    task automatic bbByte(input logic [7:0] v, input int n);
        logic rd;
        for (int i = 0; i < n; i++) bbBit(v[7 - i], rd);
        bbBit(1'h1, rd);
        ack = ~rd;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        cmdValid = 1'h0; cmdOp = 2'h0; cmdAddr = 16'h0000; cmdLen = 6'h00;
        bus2.scl = 1'h1; bus2.sdaHostOe = 1'h0; bus2.sdaHostOut = 1'h0;
        repeat (5) @(negedge linkClk);
        @(negedge core_clk);
        rst_b = 1'h1;
        @(negedge core_clk);
        `CHK("standby", 1'h1, standby)
        // byte write, page wrap from the last slot, full page
        for (int t = 0; t < 3; t++) begin
            a = $random(seed);
            if (t == 1) a[4:0] = 5'h1F;
            wr(t == 0 ? 1 : t == 1 ? 35 : 32);
        end
        cmd(ee_pkg::OP_RECOVER, 16'h0000, 0, 1'h0);
        // fault link: wrong type pattern, then a cut data byte
        bbEdge(1'h1);
        bbByte({~ee_pkg::DEV_TYPE, 4'h0}, 8);
        `CHK("mismatch", 1'h0, ack)
        bbEdge(1'h0);
        `CHK("standby2", 1'h1, standby2)
        bbEdge(1'h1);
        bbByte({ee_pkg::DEV_TYPE, ee_pkg::DEV_UNUSED, 1'h0}, 8);
        `CHK("devword", 1'h1, ack)
        bbByte(8'h01, 8);
        bbByte(8'h23, 8);
        `CHK("addr", 1'h1, ack)
        bbByte(8'h5A, 4);
        bbEdge(1'h0);
        repeat (300) @(negedge core_clk);
        `CHK("partial", 0, we2Cnt)
        `CHK("busy2", 1'h0, busy2)
        bbEdge(1'h1);
        bbByte({ee_pkg::DEV_TYPE, ee_pkg::DEV_UNUSED, 1'h1}, 8);
        `CHK("rdword", 1'h1, ack)
        `CHK("rdpark", 1'h1, standby2)
        bbEdge(1'h0);
        final_report();
    end
    initial begin
        #3_600_000;
        failCount++;
        final_report();
    end
endmodule // testbench

// File: hw/ee_dev.sv
/*
 * Memory target end: bus front end on linkClk, self-timed commit
 * of the page buffer on core_clk.
 * Assumes the controller drives the serial clock; linkClk is a free
 * running oversampling clock, much faster than the serial clock.
 */
// Overview of operation
// R1: data changes only while clock is low
// R2: data fall with clock high is start
// R3: data rise with clock high is stop
// R4: acknowledge every 8-bit word on ninth clock
// R5: standby at power-up and after finished stop
// R6: controller recovers bus with up to nine clocks
// R7: device word follows start, upper nibble compared
// R8: controller sends three unused bits as zero
// R9: lowest device word bit selects read or write
// R10: acknowledge match, mismatch returns to standby
// R11: byte write: two address bytes, one data
// R12: stop after data starts timed write cycle
// R13: ignore the bus during write cycle
// R14: page write takes up to 32 bytes
// R15: only lower five address bits increment, wrapping
// R16: acknowledge polling answered only after write done
// R17: address width 12 or 13, upper bits ignored
// R18: sample on clock rise, launch after fall
// R19: start or stop mid-byte discards that byte
`timescale 1ns/1ps
module ee_dev #(
    parameter int ADDR_W    = ee_pkg::ADDR_W_DEF,
    parameter int WR_CYCLES = ee_pkg::WR_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              linkClk,
    ee_if.dev                      bus,
    output logic                   standby,
    output logic                   writeBusy,
    output logic                   memWe,
    output logic [ADDR_W-1:0]      memAddr,
    output logic [7:0]             memData
);
    localparam int TW = $clog2(WR_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(WR_CYCLES - 1);

    typedef enum logic [3:0] {
        D_STBY = 4'h1,
        D_RX   = 4'h2,
        D_ACK  = 4'h4,
        D_BUSY = 4'h8
    } ee_dstate_e;

    typedef enum logic [2:0] {
        C_IDLE = 3'h1,
        C_SCAN = 3'h2,
        C_WAIT = 3'h4
    } ee_cstate_e;

    // ************************************************************
    // link domain synchronisers
    // ************************************************************
    logic       lrst1Q, lrstBQ;
    logic [2:0] sclSyncQ, sdaSyncQ, doneSyncQ;
    logic       doneTglQ;

    always_ff @(posedge linkClk) begin
        lrst1Q <= rst_b;
        lrstBQ <= lrst1Q;
    end

    always_ff @(posedge linkClk) begin
        sclSyncQ  <= {sclSyncQ[1:0], bus.scl};
        sdaSyncQ  <= {sdaSyncQ[1:0], bus.sda};
        doneSyncQ <= {doneSyncQ[1:0], doneTglQ};
    end

    wire sclNow   = sclSyncQ[1];
    wire sclOld   = sclSyncQ[2];
    wire sdaNow   = sdaSyncQ[1];
    wire sdaOld   = sdaSyncQ[2];
    wire sclRise  = sclNow & ~sclOld;
    wire sclFall  = ~sclNow & sclOld;
    wire startDet = sclNow & sclOld & sdaOld & ~sdaNow;   // [R1] [R2]
    wire stopDet  = sclNow & sclOld & ~sdaOld & sdaNow;   // [R1] [R3]
    wire doneEdge = doneSyncQ[1] ^ doneSyncQ[2];

    // ************************************************************
    // link domain protocol engine
    // ************************************************************
    ee_dstate_e            dstate_q;
    logic [7:0]            shift_q;
    logic [3:0]            bitCnt_q;
    logic [1:0]            idx_q;
    logic                  rdDir_q;
    logic [ADDR_W-1:0]     addr_q;
    logic [ee_pkg::PAGE_BYTES-1:0] mask_q;
    logic                  sdaOe_q;
    logic                  reqTgl_q;
    logic [7:0]            pageBuf [ee_pkg::PAGE_BYTES];

    wire devMatch  = shift_q[7:4] == ee_pkg::DEV_TYPE;    // [R7]
    wire byteFull  = bitCnt_q == 4'(ee_pkg::BYTE_BITS);
    wire haveWrite = (idx_q == 2'h3) & ~rdDir_q & (|mask_q);
    wire storeData = (dstate_q == D_ACK) & sclFall & (idx_q == 2'h3);
    wire [ee_pkg::PAGE_BITS-1:0] pageOfs = addr_q[ee_pkg::PAGE_BITS-1:0];

    always_ff @(posedge linkClk) begin
        if (!lrstBQ) begin
            dstate_q <= D_STBY;                           // [R5]
            shift_q  <= 8'h00;
            bitCnt_q <= 4'h0;
            idx_q    <= 2'h0;
            rdDir_q  <= 1'b0;
            addr_q   <= '0;
            mask_q   <= '0;
            sdaOe_q  <= 1'b0;
            reqTgl_q <= 1'b0;
        end else if (dstate_q == D_BUSY) begin
            // inputs stay dead, so a poll gets no acknowledge
            if (doneEdge) begin                           // [R13] [R16]
                dstate_q <= D_STBY;                       // [R5]
                mask_q   <= '0;
            end
        end else if (startDet) begin
            // a partial byte is dropped with the rest of the frame
            dstate_q <= D_RX;                             // [R2] [R19]
            bitCnt_q <= 4'h0;
            idx_q    <= 2'h0;
            rdDir_q  <= 1'b0;
            mask_q   <= '0;
            sdaOe_q  <= 1'b0;
        end else if (stopDet) begin
            sdaOe_q <= 1'b0;
            if (haveWrite && dstate_q == D_RX) begin
                dstate_q <= D_BUSY;                       // [R12]
                reqTgl_q <= ~reqTgl_q;
            end else begin
                dstate_q <= D_STBY;                       // [R3] [R19]
            end
        end else begin
            case (dstate_q)
                D_RX: begin
                    if (sclRise && !byteFull) begin
                        shift_q  <= {shift_q[6:0], sdaNow}; // [R18]
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall && byteFull) begin
                        if (idx_q == 2'h0 && !devMatch) begin
                            dstate_q <= D_STBY;           // [R10]
                        end else begin
                            dstate_q <= D_ACK;
                            sdaOe_q  <= 1'b1;             // [R4] [R18]
                        end
                        if (idx_q == 2'h0) begin
                            rdDir_q <= shift_q[0];        // [R9]
                        end
                        if (idx_q == 2'h1) begin
                            addr_q[ADDR_W-1:8] <= shift_q[ADDR_W-9:0];
                        end                               // [R17]
                        if (idx_q == 2'h2) begin
                            addr_q[7:0] <= shift_q;       // [R11]
                        end
                    end
                end
                D_ACK: begin
                    if (sclFall) begin
                        sdaOe_q  <= 1'b0;                 // [R4]
                        bitCnt_q <= 4'h0;
                        if (idx_q == 2'h3) begin
                            mask_q[pageOfs] <= 1'b1;      // [R14]
                            addr_q[ee_pkg::PAGE_BITS-1:0] <=
                                pageOfs + 5'h01;          // [R15]
                        end else begin
                            idx_q <= idx_q + 2'h1;
                        end
                        // reads are not served; after a read device word, park in standby
                        dstate_q <= (idx_q == 2'h0 && rdDir_q) ?
                                    D_STBY : D_RX;
                    end
                end
                default: begin
                    dstate_q <= D_STBY;
                end
            endcase
        end
    end

    always_ff @(posedge linkClk) begin
        if (storeData) begin
            pageBuf[pageOfs] <= shift_q;                  // [R15]
        end
    end

    assign bus.sdaDevOut = 1'b0;
    assign bus.sdaDevOe  = sdaOe_q;
    assign standby       = dstate_q == D_STBY;

    // ************************************************************
    // core domain: self-timed commit
    // ************************************************************
    // page buffer, mask and address hold still while the link side
    // is busy, so the core side reads them under the handshake
    ee_cstate_e        cstate_q;
    logic [2:0]        reqSyncQ;
    logic [5:0]        scan_q;
    logic [TW-1:0]     timer_q;
    logic              memWe_q;
    logic [ADDR_W-1:0] memAddr_q;
    logic [7:0]        memData_q;

    wire reqEdge = reqSyncQ[1] ^ reqSyncQ[2];
    wire [ee_pkg::PAGE_BITS-1:0] scanOfs = scan_q[ee_pkg::PAGE_BITS-1:0];

    always_ff @(posedge core_clk) begin
        reqSyncQ <= {reqSyncQ[1:0], reqTgl_q};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cstate_q  <= C_IDLE;
            scan_q    <= 6'h00;
            timer_q   <= '0;
            doneTglQ  <= 1'b0;
            memWe_q   <= 1'b0;
            memAddr_q <= '0;
            memData_q <= 8'h00;
        end else begin
            memWe_q <= 1'b0;
            if (cstate_q != C_IDLE) begin
                timer_q <= timer_q + 1'b1;
            end
            case (cstate_q)
                C_IDLE: begin
                    if (reqEdge) begin
                        cstate_q <= C_SCAN;               // [R12]
                        scan_q   <= 6'h00;
                        timer_q  <= '0;
                    end
                end
                C_SCAN: begin
                    memWe_q   <= mask_q[scanOfs];
                    memAddr_q <= {addr_q[ADDR_W-1:ee_pkg::PAGE_BITS],
                                  scanOfs};
                    memData_q <= pageBuf[scanOfs];
                    scan_q    <= scan_q + 6'h01;
                    if (scanOfs == 5'h1F) begin
                        cstate_q <= C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (timer_q == TIMER_LAST) begin
                        cstate_q <= C_IDLE;               // [R12]
                        doneTglQ <= ~doneTglQ;
                    end
                end
                default: begin
                    cstate_q <= C_IDLE;
                end
            endcase
        end
    end

    assign memWe     = memWe_q;
    assign memAddr   = memAddr_q;
    assign memData   = memData_q;
    assign writeBusy = cstate_q != C_IDLE;
endmodule // ee_dev

// File: hw/ee_host.sv
/*
 * Bus controller end: builds the serial clock from core_clk by a
 * divider and runs write, poll and bus-recovery frames.
 * Assumes the user holds write data valid until it is taken.
 */
`timescale 1ns/1ps
module ee_host #(
    parameter int PHASE_CYC = ee_pkg::PHASE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    ee_if.host               bus,
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [1:0]  cmdOp,
    input  wire logic [15:0] cmdAddr,
    input  wire logic [5:0]  cmdLen,
    input  wire logic        wrDataValid,
    input  wire logic [7:0]  wrData,
    output logic             wrDataReady,
    output logic             respValid,
    output logic             respNack
);
    localparam int CW = $clog2(PHASE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(PHASE_CYC - 1);

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_START = 5'h02,
        H_BYTE  = 5'h04,
        H_STOP  = 5'h08,
        H_RECOV = 5'h10
    } ee_hstate_e;

    ee_hstate_e  state_q;
    logic [CW-1:0] cnt_q;
    logic [1:0]  phase_q;
    logic        scl_q, sdaLow_q;
    logic [7:0]  shift_q;
    logic [3:0]  bitCnt_q;
    logic [5:0]  byteIdx_q;
    logic [1:0]  op_q;
    logic [15:0] addr_q;
    logic [5:0]  len_q;
    logic        nack_q, wrRdy_q, resp_q;
    logic [1:0]  sdaSyncQ;

    always_ff @(posedge core_clk) begin
        sdaSyncQ <= {sdaSyncQ[0], bus.sda};
    end

    wire tick     = cnt_q == CNT_LAST;
    wire sdaIn    = sdaSyncQ[1];
    wire lastByte = (op_q == ee_pkg::OP_POLL) ||
                    (byteIdx_q == len_q + 6'h03);
    wire ackSlot  = bitCnt_q == 4'(ee_pkg::BYTE_BITS);
    wire needData = byteIdx_q >= 6'h02;
    wire [7:0] devWord = {ee_pkg::DEV_TYPE, ee_pkg::DEV_UNUSED, 1'b0};
    wire [7:0] nextByte = (byteIdx_q == 6'h00) ? addr_q[15:8] :
                          (byteIdx_q == 6'h01) ? addr_q[7:0] : wrData;

    // ************************************************************
    // frame sequencer, one action per quarter bit
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q   <= H_IDLE;
            cnt_q     <= '0;
            phase_q   <= 2'h0;
            scl_q     <= 1'b1;
            sdaLow_q  <= 1'b0;
            shift_q   <= 8'h00;
            bitCnt_q  <= 4'h0;
            byteIdx_q <= 6'h00;
            op_q      <= ee_pkg::OP_WRITE;
            addr_q    <= 16'h0000;
            len_q     <= 6'h00;
            nack_q    <= 1'b0;
            wrRdy_q   <= 1'b0;
            resp_q    <= 1'b0;
        end else begin
            wrRdy_q <= 1'b0;
            resp_q  <= 1'b0;
            cnt_q   <= (tick || state_q == H_IDLE) ? '0 : cnt_q + 1'b1;
            if (tick) begin
                phase_q <= phase_q + 2'h1;
            end
            case (state_q)
                H_IDLE: begin
                    if (cmdValid) begin
                        op_q     <= cmdOp;
                        addr_q   <= cmdAddr;
                        len_q    <= cmdLen;
                        nack_q   <= 1'b0;
                        phase_q  <= 2'h0;
                        bitCnt_q <= 4'h0;
                        state_q  <= (cmdOp == ee_pkg::OP_RECOVER) ?
                                    H_RECOV : H_START;
                    end
                end
                H_START: if (tick) begin
                    case (phase_q)
                        2'h0: begin
                            scl_q    <= 1'b1;
                            sdaLow_q <= 1'b0;
                        end
                        2'h1: sdaLow_q <= 1'b1;           // [R2]
                        2'h2: scl_q <= 1'b0;
                        default: begin
                            shift_q   <= devWord;         // [R7] [R8] [R9]
                            bitCnt_q  <= 4'h0;
                            byteIdx_q <= 6'h00;
                            state_q   <= (op_q == ee_pkg::OP_RECOVER) ?
                                         H_STOP : H_BYTE;
                        end
                    endcase
                end
                H_BYTE: if (tick) begin
                    case (phase_q)
                        2'h0: sdaLow_q <= ~ackSlot & ~shift_q[7]; // [R1]
                        2'h1: scl_q <= 1'b1;
                        2'h2: if (ackSlot) nack_q <= sdaIn;  // [R4]
                        default: begin
                            scl_q    <= 1'b0;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            shift_q  <= {shift_q[6:0], 1'b0};
                            if (ackSlot) begin
                                bitCnt_q <= 4'h0;
                                if (nack_q || lastByte) begin
                                    state_q <= H_STOP;    // [R12] [R16]
                                end else if (needData && !wrDataValid) begin
                                    // hold the clock low until data
                                    bitCnt_q <= bitCnt_q;
                                    phase_q  <= phase_q;
                                end else begin
                                    shift_q   <= nextByte; // [R11] [R14]
                                    wrRdy_q   <= needData;
                                    byteIdx_q <= byteIdx_q + 6'h01;
                                end
                            end
                        end
                    endcase
                end
                H_STOP: if (tick) begin
                    case (phase_q)
                        2'h0: sdaLow_q <= 1'b1;
                        2'h1: scl_q <= 1'b1;
                        2'h2: sdaLow_q <= 1'b0;           // [R3]
                        default: begin
                            resp_q  <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    endcase
                end
                H_RECOV: if (tick) begin
                    case (phase_q)
                        2'h0: sdaLow_q <= 1'b0;
                        2'h1: scl_q <= 1'b1;
                        2'h2: if (sdaIn) begin
                            state_q <= H_START;           // [R6]
                            phase_q <= 2'h1;
                        end
                        default: begin
                            scl_q    <= 1'b0;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'(ee_pkg::RECOV_CLOCKS - 1)) begin
                                nack_q  <= 1'b1;          // [R6]
                                state_q <= H_STOP;
                            end
                        end
                    endcase
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign bus.scl        = scl_q;
    assign bus.sdaHostOut = 1'b0;
    assign bus.sdaHostOe  = sdaLow_q;
    assign cmdReady       = state_q == H_IDLE;
    assign wrDataReady    = wrRdy_q;
    assign respValid      = resp_q;
    assign respNack       = nack_q;
endmodule // ee_host

// File: hw/ee_if.sv
/*
 * Two-wire link between bus controller and memory target.
 * Assumes both ends pull data low only through their enables; the
 * line floats high otherwise.
 */
`timescale 1ns/1ps
interface ee_if;
    logic scl;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic sda;

    // open drain: any enabled driver wins with its low output
    assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

    modport host (
        output scl,
        output sdaHostOut,
        output sdaHostOe,
        input  sda
    );
    modport dev (
        input  scl,
        input  sda,
        output sdaDevOut,
        output sdaDevOe
    );
endinterface // ee_if

// File: hw/ee_pkg.sv
/*
 * Shared constants for the two-wire nonvolatile memory write path:
 * timing figures, derived cycle counts, frame layout.
 * Assumes a 25 MHz core clock on both ends.
 */
package ee_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int CORE_FREQ_KHZ = 25000;
    localparam int WR_TIME_MS    = 10;
    localparam int WR_CYCLES     = WR_TIME_MS * CORE_FREQ_KHZ;
    localparam int T_LOW_NS      = 4700;
    // each quarter of a bus bit lasts a whole low time, so every
    // setup and hold figure is met with margin
    localparam int PHASE_CYC     =
        (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CLOCKS  = 9;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int       BYTE_BITS   = 8;
    localparam int       PAGE_BYTES  = 32;
    localparam int       PAGE_BITS   = 5;
    localparam int       ADDR_W_DEF  = 13;
    // device-type pattern: value is arbitrary
    localparam logic [3:0] DEV_TYPE  = 4'h6;
    localparam logic [2:0] DEV_UNUSED = 3'h0;

    // host command codes
    localparam logic [1:0] OP_WRITE   = 2'h0;
    localparam logic [1:0] OP_POLL    = 2'h1;
    localparam logic [1:0] OP_RECOVER = 2'h2;
endpackage
